// ### logic/rds_pkg.sv
// rds_pkg: constants, types and carriers of the raw sample debug streamer.
// assumes one clock, the digital front end adc clock, drives all logic.

package rds_pkg;

  // ==========================================================================
  // port geometry
  localparam int unsigned LANES             = 4;
  localparam int unsigned SAMPLE_WIDTH      = 12;
  localparam int unsigned EDGES_PER_SAMPLE  = 3;
  localparam int unsigned SAMPLES_PER_FRAME = 4;
  localparam int unsigned FRAME_EDGES = EDGES_PER_SAMPLE * SAMPLES_PER_FRAME;
  localparam int unsigned FIFO_DEPTH        = 8;
  localparam int unsigned LEVEL_WIDTH       = 4;

  // ==========================================================================
  // rate derivation: one lane edge every ratio cycles of the adc clock
  localparam int unsigned ADC_CLOCK_MHZ = 400;
  localparam int unsigned RATE_400_MBPS = 400;
  localparam int unsigned RATE_320_MBPS = 320;
  localparam int unsigned RATE_200_MBPS = 200;
  localparam int unsigned RATE_160_MBPS = 160;
  localparam logic [3:0] RATIO_400 = 4'(ADC_CLOCK_MHZ * LANES / RATE_400_MBPS);
  localparam logic [3:0] RATIO_320 = 4'(ADC_CLOCK_MHZ * LANES / RATE_320_MBPS);
  localparam logic [3:0] RATIO_200 = 4'(ADC_CLOCK_MHZ * LANES / RATE_200_MBPS);
  localparam logic [3:0] RATIO_160 = 4'(ADC_CLOCK_MHZ * LANES / RATE_160_MBPS);

  // ==========================================================================
  // reset values
  localparam logic [3:0] EDGE_RESET  = 4'h0;
  localparam logic [1:0] SUB_RESET   = 2'h0;
  localparam logic [3:0] PHASE_RESET = 4'h0;

  typedef enum logic [1:0] {
    RDS_RATE_400 = 2'b00,
    RDS_RATE_320 = 2'b01,
    RDS_RATE_200 = 2'b10,
    RDS_RATE_160 = 2'b11
  } rds_rate_type;

  typedef enum logic [0:0] {
    RDS_IDLE = 1'b0,
    RDS_SEND = 1'b1
  } rds_mode_type;

  // pins of the raw sample debug port
  typedef struct packed {
    logic             bit_clock;
    logic             frame_marker;
    logic [LANES-1:0] debug_data_lane;
  } rds_pins_type;

  typedef struct packed {
    rds_mode_type            mode;
    logic [3:0]              ratio;
    logic [3:0]              phase;
    logic [3:0]              edge_index;
    logic [1:0]              sub;
    logic [SAMPLE_WIDTH-LANES-1:0] rest;
    rds_pins_type            pins;
  } rds_state_type;

endpackage : rds_pkg

// ### logic/rds_fifo.sv
// rds_fifo: first-word-fall-through fifo with a registered head word.
// assumes the writer honours o_in_ready and the reader honours o_out_valid.

`timescale 1ns/1ps
`default_nettype none

module rds_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  // filling side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // draining side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready,
  // words held, head register included
  output logic [$clog2(DEPTH+2)-1:0] o_level
);

  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH+2);

  typedef struct packed {
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic             out_valid;
    logic [WIDTH-1:0] out_data;
  } rds_fifo_state_type;

  logic [WIDTH-1:0]   mem_reg [DEPTH];
  rds_fifo_state_type state_reg;
  rds_fifo_state_type state_next;
  logic               push;
  logic               pop;
  logic               load;

  // ==========================================================================
  // control
  always_comb begin
    state_next = state_reg;
    push = i_in_valid && (state_reg.count < CW'(DEPTH));
    pop  = state_reg.out_valid && i_out_ready;
    // head refills from storage on the same edge that it is taken, or on the next edge once it is empty
    load = (state_reg.count != '0) && (!state_reg.out_valid || pop);
    if (push) begin
      state_next.wr_ptr = state_reg.wr_ptr + PW'(1);
    end
    if (load) begin
      state_next.rd_ptr   = state_reg.rd_ptr + PW'(1);
      state_next.out_data = mem_reg[state_reg.rd_ptr];
    end
    state_next.count = state_reg.count + CW'(push) - CW'(load);
    state_next.out_valid = load || (state_reg.out_valid && !pop);
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // storage holds no control state, so it needs no reset
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_reg[state_reg.wr_ptr] <= i_in_data;
    end
  end

  assign o_in_ready  = state_reg.count < CW'(DEPTH);
  assign o_out_valid = state_reg.out_valid;
  assign o_out_data  = state_reg.out_data;
  assign o_level     = state_reg.count + CW'(state_reg.out_valid);

endmodule : rds_fifo

`default_nettype wire

// ### logic/rds_streamer.sv
// rds_streamer: serialises raw receive channel samples onto the four lane
// raw sample debug port with a continuous bit clock and a frame marker.
// assumes i_clock is the 400 MHz adc clock chosen for the digital front end
// and that samples arrive already in channel order.

`timescale 1ns/1ps
`default_nettype none

module rds_streamer (
  // clock and reset
  input  wire logic                                i_clock,
  input  wire logic                                i_reset,
  // configuration
  input  wire logic [1:0]                          i_rate_select,
  // sample input
  input  wire logic                                i_sample_valid,
  input  wire logic [rds_pkg::SAMPLE_WIDTH-1:0]    i_sample_data,
  output logic                                     o_sample_ready,
  // raw sample debug port
  output logic                                     o_bit_clock,
  output logic                                     o_frame_marker,
  output logic [rds_pkg::LANES-1:0]                o_debug_data_lane
);

  localparam int unsigned SW = rds_pkg::SAMPLE_WIDTH;
  localparam int unsigned LW = rds_pkg::LANES;

  rds_pkg::rds_state_type state_reg;
  rds_pkg::rds_state_type state_next;
  logic                   head_valid;
  logic [SW-1:0]          head_data;
  logic                   head_take;
  logic [3:0]             level;
  logic [3:0]             ratio_sel;
  logic                   launch;
  logic                   frame_ready;

  // ==========================================================================
  // sample buffer
  rds_fifo #(
    .WIDTH (SW),
    .DEPTH (rds_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_reset     (i_reset),
    .i_in_valid  (i_sample_valid),
    .i_in_data   (i_sample_data),
    .o_in_ready  (o_sample_ready),
    .o_out_valid (head_valid),
    .o_out_data  (head_data),
    .i_out_ready (head_take),
    .o_level     (level)
  );

  // ==========================================================================
  // rate select
  always_comb begin
    case (rds_pkg::rds_rate_type'(i_rate_select))
      rds_pkg::RDS_RATE_400: ratio_sel = rds_pkg::RATIO_400;
      rds_pkg::RDS_RATE_320: ratio_sel = rds_pkg::RATIO_320;
      rds_pkg::RDS_RATE_200: ratio_sel = rds_pkg::RATIO_200;
      rds_pkg::RDS_RATE_160: ratio_sel = rds_pkg::RATIO_160;
      default:               ratio_sel = rds_pkg::RATIO_400;
    endcase
  end

  // ==========================================================================
  // framing and serialising
  always_comb begin
    state_next = state_reg;
    head_take  = 1'b0;
    // data launch half an edge period before the clock toggles, so marker
    // and lanes are centred on each active edge
    launch = (state_reg.phase == rds_pkg::PHASE_RESET);
    // starting only while the clock is low makes the next toggle a rise
    frame_ready = (level >= 4'(rds_pkg::SAMPLES_PER_FRAME))
                  && head_valid && !state_reg.pins.bit_clock;

    // free running edge divider off the adc clock
    if (state_reg.phase == state_reg.ratio - 4'h1) begin
      state_next.phase = rds_pkg::PHASE_RESET;
    end else begin
      state_next.phase = state_reg.phase + 4'h1;
    end
    if (state_reg.phase == (state_reg.ratio >> 1)) begin
      state_next.pins.bit_clock = !state_reg.pins.bit_clock;
    end

    if (launch) begin
      case (state_reg.mode)
        rds_pkg::RDS_IDLE: begin
          // rate changes only take effect between frames
          state_next.ratio = ratio_sel;
          state_next.phase = 4'h1;
          if (frame_ready) begin
            head_take                  = 1'b1;
            state_next.mode            = rds_pkg::RDS_SEND;
            state_next.edge_index      = rds_pkg::EDGE_RESET;
            state_next.sub             = rds_pkg::SUB_RESET;
            state_next.pins.frame_marker = 1'b1;
            state_next.pins.debug_data_lane = head_data[SW-1 -: LW];
            state_next.rest            = head_data[SW-LW-1:0];
          end else begin
            state_next.pins.frame_marker    = 1'b0;
            state_next.pins.debug_data_lane = '0;
          end
        end
        rds_pkg::RDS_SEND: begin
          if (state_reg.edge_index ==
              4'(rds_pkg::FRAME_EDGES - 1)) begin
            state_next.ratio = ratio_sel;
            if (frame_ready) begin
              // back to back frame, clock is low again after twelve edges
              head_take                  = 1'b1;
              state_next.edge_index      = rds_pkg::EDGE_RESET;
              state_next.sub             = rds_pkg::SUB_RESET;
              state_next.pins.debug_data_lane = head_data[SW-1 -: LW];
              state_next.rest            = head_data[SW-LW-1:0];
            end else begin
              state_next.mode              = rds_pkg::RDS_IDLE;
              state_next.pins.frame_marker = 1'b0;
              state_next.pins.debug_data_lane = '0;
            end
          end else begin
            state_next.edge_index = state_reg.edge_index + 4'h1;
            if (state_reg.sub ==
                2'(rds_pkg::EDGES_PER_SAMPLE - 1)) begin
              // next channel only after all three nibbles went out
              head_take      = 1'b1;
              state_next.sub = rds_pkg::SUB_RESET;
              state_next.pins.debug_data_lane = head_data[SW-1 -: LW];
              state_next.rest = head_data[SW-LW-1:0];
            end else begin
              state_next.sub = state_reg.sub + 2'h1;
              state_next.pins.debug_data_lane =
                state_reg.rest[SW-LW-1 -: LW];
              state_next.rest = {state_reg.rest[SW-2*LW-1:0], {LW{1'b0}}};
            end
          end
        end
        default: begin
          state_next.mode = rds_pkg::RDS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_reg       <= '0;
      state_reg.ratio <= rds_pkg::RATIO_400;
    end else begin
      state_reg <= state_next;
    end
  end

  // dedicated pins
  assign o_bit_clock       = state_reg.pins.bit_clock;
  assign o_frame_marker    = state_reg.pins.frame_marker;
  assign o_debug_data_lane = state_reg.pins.debug_data_lane;

endmodule : rds_streamer

`default_nettype wire

// ### dv/rds_streamer_checker.sv
// rds_streamer_checker: port assertions for the debug streamer.
// assumes it is bound to rds_streamer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rds_streamer_checker (
  input wire logic        i_clock,
  input wire logic        i_reset,
  input wire logic [1:0]  i_rate_select,
  input wire logic        i_sample_valid,
  input wire logic [11:0] i_sample_data,
  input wire logic        o_sample_ready,
  input wire logic        o_bit_clock,
  input wire logic        o_frame_marker,
  input wire logic [3:0]  o_debug_data_lane
);
  // ==========================================================================
  // helper counters
  logic        clk_d;
  logic        mark_d;
  logic [7:0]  frame_tog;
  logic [15:0] all_tog;
  logic [15:0] taken;
  wire         tog = o_bit_clock != clk_d;
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      clk_d     <= 1'b0;
      mark_d    <= 1'b0;
      frame_tog <= 8'h00;
      all_tog   <= 16'h0000;
      taken     <= 16'h0000;
    end else begin
      clk_d     <= o_bit_clock;
      mark_d    <= o_frame_marker;
      frame_tog <= (o_frame_marker && !mark_d) ? 8'h00 :
                   frame_tog + 8'(tog && o_frame_marker);
      all_tog   <= all_tog + 16'(tog && o_frame_marker);
      taken     <= taken + 16'(i_sample_valid && o_sample_ready);
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // ==========================================================================
  // assertions
  frame_rise_a :
    assert property ($rose(o_frame_marker) |-> !o_bit_clock)
    else $error("frame began with bit clock high");
  frame_length_a :
    assert property ($fell(o_frame_marker) |->
                     frame_tog != 8'h00 && frame_tog % 12 == 0)
    else $error("frame not a multiple of twelve edges");
  clock_runs_a :
    assert property (1'b1 |-> ##[1:11] tog)
    else $error("bit clock stalled");
  edge_holds_a :
    assert property (tog |-> $stable(o_debug_data_lane)
                     && $stable(o_frame_marker))
    else $error("lanes moved on a bit clock edge");
  launch_mid_a :
    assert property ($changed(o_debug_data_lane) |-> !tog ##1 !tog)
    else $error("lane change too close to an edge");
  idle_lanes_a :
    assert property (!o_frame_marker |-> o_debug_data_lane == 4'h0)
    else $error("lanes driven outside a frame");
  full_group_a :
    assert property ($rose(o_frame_marker) |->
                     taken >= 16'(4 * (all_tog / 12) + 4))
    else $error("frame began without four samples");
  reset_quiet_a :
    assert property (disable iff (1'b0) i_reset |=> !o_bit_clock
                     && !o_frame_marker && o_sample_ready)
    else $error("outputs not quiet after reset");
endmodule : rds_streamer_checker
bind rds_streamer rds_streamer_checker i_chk (
  .i_clock(i_clock), .i_reset(i_reset), .i_rate_select(i_rate_select),
  .i_sample_valid(i_sample_valid), .i_sample_data(i_sample_data),
  .o_sample_ready(o_sample_ready), .o_bit_clock(o_bit_clock),
  .o_frame_marker(o_frame_marker), .o_debug_data_lane(o_debug_data_lane)
);
`default_nettype wire

// ### dv/rds_capture_model.sv
// rds_capture_model: capture receiver rebuilding samples from the lanes.
// assumes it samples the port in the streamer's own clock domain.
`timescale 1ns/1ps
`default_nettype none
module rds_capture_model (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_bit_clock,
  input  wire logic        i_frame_marker,
  input  wire logic [3:0]  i_lanes,
  output logic             o_got_valid,
  output logic [11:0]      o_got_data,
  output logic [7:0]       o_edge_gap,
  output logic             o_fall_start
);
  logic       clk_d;
  logic       first;
  logic [1:0] nib;
  logic [7:0] shift;
  logic [7:0] gap;
  always_ff @(posedge i_clock) begin
    o_got_valid <= 1'b0;
    if (i_reset) begin
      clk_d        <= 1'b0;
      first        <= 1'b1;
      nib          <= 2'h0;
      gap          <= 8'h00;
      o_edge_gap   <= 8'h00;
      o_fall_start <= 1'b0;
    end else begin
      clk_d <= i_bit_clock;
      gap   <= gap + 8'h01;
      if (i_bit_clock != clk_d) begin
        // edge spacing kept even between frames
        gap        <= 8'h01;
        o_edge_gap <= gap;
        if (i_frame_marker) begin
          shift <= {shift[3:0], i_lanes};
          nib   <= (nib == 2'h2) ? 2'h0 : nib + 2'h1;
          if (nib == 2'h2) begin
            o_got_valid <= 1'b1;
            o_got_data  <= {shift, i_lanes};
          end
          if (first && !i_bit_clock) o_fall_start <= 1'b1;
          first <= 1'b0;
        end
      end
      // gaps between frames are tolerated
      if (!i_frame_marker) begin
        first <= 1'b1;
        nib   <= 2'h0;
      end
    end
  end
endmodule : rds_capture_model
`default_nettype wire

// ### dv/rds_streamer_bench.sv
// rds_streamer_bench: self-checking bench of the debug streamer.
// assumes rds_capture_model rebuilds samples from the port.
`timescale 1ns/1ps
`default_nettype none
module rds_streamer_bench;
  logic        i_clock        = 1'b0;
  logic        i_reset        = 1'b1;
  logic [1:0]  i_rate_select  = 2'b00;
  logic        i_sample_valid = 1'b0;
  logic [11:0] i_sample_data  = 12'h000;
  logic        o_sample_ready, o_bit_clock, o_frame_marker;
  logic [3:0]  o_debug_data_lane;
  logic        got_valid, fall_start;
  logic        saw_full = 1'b0;
  logic [11:0] got_data;
  logic [7:0]  edge_gap;
  logic [11:0] exp_q[$];
  int          error_cnt = 0, check_count = 0, seed = 63664;
  int          gap_exp;
  int          rates[4] = '{400, 320, 200, 160};
  always #20 i_clock = ~i_clock;
  rds_streamer i_dut (.i_clock(i_clock), .i_reset(i_reset),
    .i_rate_select(i_rate_select), .i_sample_valid(i_sample_valid),
    .i_sample_data(i_sample_data), .o_sample_ready(o_sample_ready),
    .o_bit_clock(o_bit_clock), .o_frame_marker(o_frame_marker),
    .o_debug_data_lane(o_debug_data_lane));
  rds_capture_model i_rx (.i_clock(i_clock), .i_reset(i_reset),
    .i_bit_clock(o_bit_clock), .i_frame_marker(o_frame_marker),
    .i_lanes(o_debug_data_lane), .o_got_valid(got_valid),
    .o_got_data(got_data), .o_edge_gap(edge_gap),
    .o_fall_start(fall_start));
  // ==========================================================================
  // shared tasks
  task check(input string what, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task put(input logic [11:0] d);
    #1 i_sample_valid = 1'b1;
    i_sample_data = d;
    do @(posedge i_clock); while (o_sample_ready !== 1'b1);
    exp_q.push_back(d);
  endtask : put
  task idle(input int n);
    #1 i_sample_valid = 1'b0;
    repeat (n) @(posedge i_clock);
  endtask : idle
  task send(input int n);
    int gap;
    repeat (n) begin
      put(12'($random(seed)));
      gap = $unsigned($random(seed)) % 3;
      // back to back words keep valid high instead of glitching it low
      if (gap != 0) idle(gap);
    end
    idle(0);
  endtask : send
  task drain;
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < 3000) begin
      @(posedge i_clock);
      k++;
    end
    check("drained", 16'(exp_q.size()), 16'h0000);
    repeat (30) @(posedge i_clock);
  endtask : drain
  task summarize;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // monitor takes the oldest note whenever a sample comes out
  always @(posedge i_clock) begin
    if (i_sample_valid && !o_sample_ready) saw_full <= 1'b1;
    if (got_valid === 1'b1) begin
      if (exp_q.size() == 0) check("extra sample", 16'h1, 16'h0);
      else check("sample", got_data, exp_q.pop_front());
    end
  end
  initial begin
    #400000;
    check("watchdog", 16'h0, 16'h1);
    summarize();
  end
  initial begin
    repeat (2) @(posedge i_clock);
    #1 i_reset = 1'b0;
    for (int r = 0; r < 4; r++) begin
      @(posedge i_clock);
      #1 i_rate_select = 2'(r);
      @(posedge i_clock);
      send(8);
      drain();
      gap_exp = rds_pkg::ADC_CLOCK_MHZ * rds_pkg::LANES / rates[r];
      check("edge gap", 16'(edge_gap), 16'(gap_exp));
      $display("test rate %0d done", rates[r]);
    end
    // three samples must not open a frame
    send(3);
    repeat (300) @(posedge i_clock);
    check("held samples", 16'(exp_q.size()), 16'h0003);
    check("marker idle", 16'(o_frame_marker), 16'h0000);
    send(1);
    drain();
    $display("test partial group done");
    // slowest rate, source never pauses, so the fifo must refuse
    for (int i = 0; i < 20; i++) put(12'($random(seed)));
    idle(0);
    check("refused", 16'(saw_full), 16'h0001);
    drain();
    check("ready", 16'(o_sample_ready), 16'h0001);
    check("rise start", 16'(fall_start), 16'h0000);
    $display("test full fifo done");
    summarize();
  end
endmodule : rds_streamer_bench
`default_nettype wire
